// *** rtl/sdc_host.sv ***
// module: apb-driven command host for a four-bank synchronous dram
`timescale 1ns/10ps
`default_nettype none
module sdc_host
  import sdc_pkg::*;
#(
  parameter int RFC_N = RFC_CYC
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  output sdc_pins_t mem,
  output logic [DW-1:0] dq_o,
  output logic dq_oe,
  input wire logic [DW-1:0] dq_i
);
  // ---------------------------------------------
  // state
  // ---------------------------------------------
  sdc_st_t st_r;
  sdc_op_t op_r;
  logic a10_r;
  logic [1:0] ba_r;
  logic [AW-1:0] addr_r;
  logic [DW-1:0] wdata_r;
  logic [MW-1:0] mask_r;
  logic [1:0] lat_r;
  logic [3:0] open_r;
  logic ref_r;
  logic [DW-1:0] rdata_r;
  logic [CW-1:0] cnt_r;
  logic [DW-1:0] sync1_r;
  logic [DW-1:0] sync2_r;
  logic [31:0] prdata_r;
  logic pslverr_r;
  sdc_pins_t pins_r;
  logic dq_oe_r;
  logic [DW-1:0] dq_o_r;

  logic acc_wr;
  logic ctrl_wr;
  sdc_op_t new_op;
  logic [1:0] new_ba;
  logic new_a10;
  logic ok;
  logic go;
  logic refuse;
  logic rd_cap;

  // ---------------------------------------------
  // helpers
  // ---------------------------------------------
  function automatic logic [2:0] enc(input sdc_op_t op);
    case (op)
      OP_ACT: enc = 3'b011;
      OP_RD: enc = 3'b101;
      OP_WR: enc = 3'b100;
      OP_BST: enc = 3'b110;
      OP_PRE: enc = 3'b010;
      OP_REF, OP_SREF: enc = 3'b001;
      OP_LMR: enc = 3'b000;
      default: enc = 3'b111;
    endcase
  endfunction : enc

  function automatic logic [CW-1:0] hold(input sdc_op_t op, input logic a10,
                                         input logic [1:0] lat);
    logic [CW-1:0] t;
    t = a10 ? CW'(TRP_CYC) : '0;
    case (op)
      OP_RD: hold = CW'(lat) + 8'h01 + t;
      OP_WR: hold = t;
      OP_PRE: hold = CW'(TRP_CYC - 1);
      OP_LMR: hold = CW'(MRD_CYC - 1);
      OP_REF: hold = CW'(RFC_N - 1);
      OP_SRX: hold = CW'(XSR_CYC - 1);
      default: hold = '0;
    endcase
  endfunction : hold

  // ---------------------------------------------
  // command acceptance
  // ---------------------------------------------
  assign acc_wr = psel && penable && pwrite;
  assign ctrl_wr = acc_wr && (paddr == OFS_CTRL);
  assign new_op = sdc_op_t'(pwdata[3:0]);
  assign new_ba = pwdata[CTRL_BA_LSB+1:CTRL_BA_LSB];
  assign new_a10 = pwdata[CTRL_A10_BIT];

  always_comb begin
    ok = (st_r == ST_IDLE) && (pwdata[3:0] <= 4'h9);
    case (new_op)
      OP_ACT: ok = ok && !open_r[new_ba];
      OP_RD, OP_WR: ok = ok && open_r[new_ba];
      OP_LMR: ok = ok && (open_r == 4'h0) && !new_ba[0];
      OP_REF, OP_SREF: ok = ok && (open_r == 4'h0);
      OP_SRX: ok = (st_r == ST_SREF);
      default: ok = ok;
    endcase
  end

  assign go = ctrl_wr && ok;
  assign refuse = ctrl_wr && !ok;
  assign rd_cap = (st_r == ST_WAIT) && (op_r == OP_RD)
    && (cnt_r == (a10_r ? CW'(TRP_CYC) : CW'(0)));

  // ---------------------------------------------
  // sequencer
  // ---------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_r <= ST_IDLE;
      op_r <= OP_NOP;
      a10_r <= 1'b0;
      ba_r <= 2'h0;
      cnt_r <= '0;
    end else begin
      case (st_r)
        ST_IDLE: begin
          if (go) begin
            st_r <= ST_CMD;
            op_r <= new_op;
            a10_r <= new_a10;
            ba_r <= new_ba;
          end
        end
        ST_CMD: begin
          cnt_r <= hold(op_r, a10_r, lat_r);
          st_r <= (op_r == OP_SREF) ? ST_SREF : ST_WAIT;
        end
        ST_WAIT: begin
          if (cnt_r == '0) begin
            st_r <= ST_IDLE;
          end else begin
            cnt_r <= cnt_r - 8'h01;
          end
        end
        ST_SREF: begin
          if (go) begin
            st_r <= ST_CMD;
            op_r <= OP_SRX;
          end
        end
        default: st_r <= ST_IDLE;
      endcase
    end
  end

  // ---------------------------------------------
  // bank tracking
  // ---------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      open_r <= 4'h0;
    end else if (go) begin
      case (new_op)
        OP_ACT: open_r[new_ba] <= 1'b1;
        OP_RD, OP_WR: begin
          if (new_a10) begin
            open_r[new_ba] <= 1'b0;
          end
        end
        OP_PRE: begin
          if (new_a10) begin
            open_r <= 4'h0;
          end else begin
            open_r[new_ba] <= 1'b0;
          end
        end
        default: open_r <= open_r;
      endcase
    end
  end

  // ---------------------------------------------
  // pin drive
  // ---------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pins_r <= '{cke: 1'b1, cs_n: 1'b1, ras_n: 1'b1, cas_n: 1'b1,
                  we_n: 1'b1, ba: 2'h0, addr: '0, dqm: '1};
      dq_oe_r <= 1'b0;
      dq_o_r <= '0;
    end else begin
      dq_oe_r <= go && (new_op == OP_WR);
      dq_o_r <= wdata_r;
      if (go) begin
        pins_r.cke <= (new_op != OP_SREF);
        pins_r.cs_n <= 1'b0;
        {pins_r.ras_n, pins_r.cas_n, pins_r.we_n} <= enc(new_op);
        pins_r.ba <= new_ba;
        pins_r.addr <= addr_r;
        if (new_op inside {OP_RD, OP_WR, OP_PRE}) begin
          pins_r.addr[10] <= new_a10;
        end
        pins_r.dqm <= (new_op inside {OP_RD, OP_WR}) ? mask_r : '1;
      end else if (st_r == ST_SREF || (st_r == ST_CMD && op_r == OP_SREF)) begin
        pins_r.cke <= 1'b0;
        pins_r.cs_n <= 1'b1;
      end else begin
        pins_r.cke <= 1'b1;
        pins_r.cs_n <= 1'b0;
        {pins_r.ras_n, pins_r.cas_n, pins_r.we_n} <= 3'b111;
        // mask stands before the read too: at latency one it is sampled ahead of the command
        pins_r.dqm <= mask_r;
      end
    end
  end

  assign mem = pins_r;
  assign dq_o = dq_o_r;
  assign dq_oe = dq_oe_r;

  // ---------------------------------------------
  // read capture
  // ---------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sync1_r <= '0;
      sync2_r <= '0;
      rdata_r <= '0;
    end else begin
      sync1_r <= dq_i;
      sync2_r <= sync1_r;
      if (rd_cap) begin
        rdata_r <= sync2_r;
      end
    end
  end

  // ---------------------------------------------
  // register file
  // ---------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      addr_r <= '0;
      wdata_r <= '0;
      mask_r <= MASK_RST;
      lat_r <= LAT_RST;
    end else if (acc_wr) begin
      case (paddr)
        OFS_ADDR: addr_r <= pwdata[AW-1:0];
        OFS_WDATA: wdata_r <= pwdata[DW-1:0];
        OFS_MASK: mask_r <= pwdata[MW-1:0];
        OFS_CFG: lat_r <= pwdata[1:0];
        default: lat_r <= lat_r;
      endcase
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ref_r <= 1'b0;
    end else if (refuse) begin
      ref_r <= 1'b1;
    end else if (acc_wr && paddr == OFS_STAT && pwdata[STAT_REF_BIT]) begin
      ref_r <= 1'b0;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata_r <= '0;
      pslverr_r <= 1'b0;
    end else if (psel && !penable) begin
      pslverr_r <= 1'b0;
      case (paddr)
        OFS_CTRL: prdata_r <= {25'h0, a10_r, ba_r, op_r};
        OFS_ADDR: prdata_r <= {20'h0, addr_r};
        OFS_WDATA: prdata_r <= {16'h0, wdata_r};
        OFS_MASK: prdata_r <= {30'h0, mask_r};
        OFS_CFG: prdata_r <= {30'h0, lat_r};
        // self refresh is not busy, so software may write the exit command
        OFS_STAT: prdata_r <= {24'h0, open_r, 1'b0,
                               st_r == ST_SREF, ref_r, st_r inside {ST_CMD, ST_WAIT}};
        OFS_RDATA: prdata_r <= {16'h0, rdata_r};
        default: begin
          prdata_r <= '0;
          pslverr_r <= 1'b1;
        end
      endcase
    end
  end

  assign prdata = prdata_r;
  assign pslverr = pslverr_r;
  assign pready = 1'b1;

  // ---------------------------------------------
  // checks
  // ---------------------------------------------
  logic exec;
  logic is_rd;
  logic is_wr;
  logic is_lmr;
  logic is_ref;
  logic is_pre;
  assign exec = !pins_r.cs_n
    && ({pins_r.ras_n, pins_r.cas_n, pins_r.we_n} != 3'b111);
  assign is_rd = exec && {pins_r.ras_n, pins_r.cas_n, pins_r.we_n} == 3'b101;
  assign is_wr = exec && {pins_r.ras_n, pins_r.cas_n, pins_r.we_n} == 3'b100;
  assign is_lmr = exec && {pins_r.ras_n, pins_r.cas_n, pins_r.we_n} == 3'b000;
  assign is_ref = exec && {pins_r.ras_n, pins_r.cas_n, pins_r.we_n} == 3'b001;
  assign is_pre = exec && {pins_r.ras_n, pins_r.cas_n, pins_r.we_n} == 3'b010;

  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  chk_act_pins: assert property ((go && new_op == OP_ACT) |=>
    exec && {pins_r.ras_n, pins_r.cas_n, pins_r.we_n} == 3'b011
    && open_r[pins_r.ba]) else $error("active not issued to opened bank");
  chk_rw_open: assert property ((is_rd || is_wr) && !pins_r.addr[10] |->
    open_r[pins_r.ba]) else $error("access to closed bank");
  chk_lmr_idle: assert property (is_lmr |-> open_r == 4'h0
    && !pins_r.ba[0]) else $error("mode load with open bank");
  chk_mrd_gap: assert property (is_lmr |=> !exec ##1 !exec)
    else $error("command inside mode load delay");
  chk_ref_idle: assert property (is_ref && pins_r.cke |-> open_r == 4'h0)
    else $error("refresh with open bank");
  chk_sref_cke: assert property (is_ref && !pins_r.cke |=>
    !pins_r.cke && pins_r.cs_n) else $error("self refresh lost clock enable");
  chk_pre_gap: assert property (is_pre |=> !exec)
    else $error("command inside recovery time");
  chk_wr_data: assert property (is_wr |-> dq_oe ##1 !dq_oe)
    else $error("write data not with write command");
  chk_rd_lat2: assert property (is_rd && lat_r == 2'h2 |-> ##4 rd_cap)
    else $error("read capture not at latency");
  chk_rd_mask: assert property (is_rd |=> $stable(pins_r.dqm))
    else $error("read mask not held");
endmodule : sdc_host
`default_nettype wire

// *** rtl/sdc_pkg.sv ***
// package: constants, types and pin bundle of the sdram command host
package sdc_pkg;
  localparam int DW = 16;
  localparam int AW = 12;
  localparam int MW = 2;
  localparam int CW = 8;
  // ---------------------------------------------
  // register offsets
  // ---------------------------------------------
  localparam logic [7:0] OFS_CTRL = 8'h00;
  localparam logic [7:0] OFS_ADDR = 8'h04;
  localparam logic [7:0] OFS_WDATA = 8'h08;
  localparam logic [7:0] OFS_MASK = 8'h0C;
  localparam logic [7:0] OFS_CFG = 8'h10;
  localparam logic [7:0] OFS_STAT = 8'h14;
  localparam logic [7:0] OFS_RDATA = 8'h18;
  // ---------------------------------------------
  // field positions and reset values
  // ---------------------------------------------
  localparam int CTRL_BA_LSB = 4;
  localparam int CTRL_A10_BIT = 6;
  localparam int STAT_REF_BIT = 1;
  localparam logic [1:0] LAT_RST = 2'h2;
  localparam logic [MW-1:0] MASK_RST = 2'h0;
  // ---------------------------------------------
  // timing
  // ---------------------------------------------
  localparam int CLK_NS = 40;
  localparam int TRP_NS = 20;
  localparam int TRFC_NS = 80;
  localparam int TRP_CYC = (TRP_NS + CLK_NS - 1) / CLK_NS;
  localparam int RFC_CYC = (TRFC_NS + CLK_NS - 1) / CLK_NS;
  localparam int MRD_CYC = 2;
  localparam int XSR_CYC = 2;
  // ---------------------------------------------
  // types
  // ---------------------------------------------
  typedef enum logic [3:0] {
    OP_NOP, OP_ACT, OP_RD, OP_WR, OP_BST,
    OP_PRE, OP_REF, OP_SREF, OP_LMR, OP_SRX
  } sdc_op_t;
  typedef enum logic [1:0] {ST_IDLE, ST_CMD, ST_WAIT, ST_SREF} sdc_st_t;
  typedef struct packed {
    logic cke;
    logic cs_n;
    logic ras_n;
    logic cas_n;
    logic we_n;
    logic [1:0] ba;
    logic [AW-1:0] addr;
    logic [MW-1:0] dqm;
  } sdc_pins_t;
endpackage : sdc_pkg

// *** dv/sdc_mem_model.sv ***
// partner model: four-bank sdram that answers the command host pins
`timescale 1ns/10ps
`default_nettype none
module sdc_mem_model
  import sdc_pkg::*;
(
  input wire logic clk,
  input wire sdc_pins_t mem,
  input wire logic [DW-1:0] dq_o,
  input wire logic dq_oe,
  output logic [DW-1:0] dq_i,
  output sdc_op_t last_op,
  output int errs
);
  // op-code field positions, plain defaults
  localparam int LAT_LSB = 4;
  localparam int PAR_LSB = 0;
  logic [DW-1:0] arr [4][16];
  logic [DW-1:0] rd_r [3];
  logic [DW-1:0] last_r;
  logic [3:0] open_r = 4'h0;
  logic sref_r = 1'b0;
  logic [1:0] lat_r = 2'h2;
  logic [2:0] par_r = 3'h0;
  logic [2:0] rv_r = 3'h0;
  logic [MW-1:0] m1_r, m2_r;
  logic [2:0] rcw;
  logic [1:0] b;
  int keep;
  initial errs = 0;
  initial last_op = OP_NOP;
  assign rcw = {mem.ras_n, mem.cas_n, mem.we_n};
  assign b = mem.ba;
  assign keep = (par_r == 3'h1) ? 2 : (par_r == 3'h2) ? 1 : 4;
  // ---------------------------------------------
  // read lanes: masked or idle lanes never hold old data
  // ---------------------------------------------
  always_comb
    for (int i = 0; i < MW; i++)
      dq_i[i*8+:8] = (rv_r[lat_r-1] && !m2_r[i]) ? rd_r[lat_r-1][i*8+:8]
                                                 : ~last_r[i*8+:8];
  // ---------------------------------------------
  // command decode
  // ---------------------------------------------
  always @(posedge clk) begin
    last_r <= dq_i;
    m1_r <= mem.dqm;
    m2_r <= m1_r;
    rv_r <= {rv_r[1:0], 1'b0};
    rd_r[1] <= rd_r[0];
    rd_r[2] <= rd_r[1];
    if (sref_r) begin
      if (mem.cke) begin
        sref_r <= 1'b0;
        last_op <= OP_SRX;
      end
    end else if (!mem.cs_n && rcw != 3'b111) begin
      case (rcw)
        3'b011: begin
          if (open_r[b]) errs <= errs + 1;
          open_r[b] <= 1'b1;
          last_op <= OP_ACT;
        end
        3'b101: begin
          if (!open_r[b]) errs <= errs + 1;
          rv_r[0] <= 1'b1;
          rd_r[0] <= arr[b][mem.addr[3:0]];
          if (mem.addr[10]) open_r[b] <= 1'b0;
          last_op <= OP_RD;
        end
        3'b100: begin
          if (!open_r[b] || dq_oe !== 1'b1) errs <= errs + 1;
          for (int i = 0; i < MW; i++)
            if (!mem.dqm[i]) arr[b][mem.addr[3:0]][i*8+:8] <= dq_o[i*8+:8];
          if (mem.addr[10]) open_r[b] <= 1'b0;
          last_op <= OP_WR;
        end
        3'b110: last_op <= OP_BST;
        3'b010: begin
          if (mem.addr[10]) open_r <= 4'h0;
          else open_r[b] <= 1'b0;
          last_op <= OP_PRE;
        end
        3'b001: begin
          if (|open_r) errs <= errs + 1;
          if (mem.cke) last_op <= OP_REF;
          else begin
            sref_r <= 1'b1;
            last_op <= OP_SREF;
            for (int j = 0; j < 4; j++)
              for (int c = 0; c < 16; c++)
                if (j >= keep) arr[j][c] <= ~arr[j][c];
          end
        end
        default: begin
          if (|open_r) errs <= errs + 1;
          if (b == 2'h0) lat_r <= mem.addr[LAT_LSB+:2];
          else if (b == 2'h2) par_r <= mem.addr[PAR_LSB+:3];
          else errs <= errs + 1;
          last_op <= OP_LMR;
        end
      endcase
    end
  end
endmodule : sdc_mem_model
`default_nettype wire

// *** dv/sdc_host_tb_top.sv ***
// testbench: apb-driven scenarios against the sdram model
`timescale 1ns/10ps
`default_nettype none
module sdc_host_tb_top
  import sdc_pkg::*;
;
  logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, pready, pslverr, dq_oe, slv;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0000_0000, prdata, q;
  logic [DW-1:0] dq_o, dq_i;
  sdc_pins_t mem;
  sdc_op_t last_op;
  int errs, miscompares = 0, n_checks = 0;
  always #20 pclk = ~pclk;
  sdc_host #(.RFC_N(1)) uut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .mem(mem), .dq_o(dq_o), .dq_oe(dq_oe), .dq_i(dq_i));
  sdc_mem_model mdl (.clk(pclk), .mem(mem), .dq_o(dq_o), .dq_oe(dq_oe), .dq_i(dq_i),
    .last_op(last_op), .errs(errs));
  // ---------------------------------------------
  // shared tasks
  // ---------------------------------------------
  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", n_checks, miscompares);
    if (miscompares == 0 && n_checks > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask : report_and_stop
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    n_checks++;
    if (g !== e) begin
      $display("[ERR] %s expected %h seen %h", nm, e, g);
      miscompares++;
    end
  endtask : chk
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int k;
    k = 0;
    psel <= 1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1;
    do begin
      @(posedge pclk);
      k++;
    end while (pready !== 1'b1 && k < 50);
    q = prdata;
    slv = pslverr;
    psel <= 0;
    penable <= 0;
    if (k >= 50) begin
      miscompares++;
      report_and_stop();
    end
    @(posedge pclk);
  endtask : apb
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask : wr
  task automatic stat(input logic [3:0] eb, input logic es);
    apb(1'b0, OFS_STAT, 32'h0000_0000);
    chk("status", {27'h0, eb, es}, {27'h0, q[7:4], q[2]});
  endtask : stat
  task automatic cmd(input logic [3:0] op, input logic [1:0] ba, input logic a10,
                     input logic [11:0] ad, input logic refd, input sdc_op_t eop);
    int k;
    k = 0;
    wr(OFS_ADDR, {20'h0, ad});
    wr(OFS_CTRL, {25'h0, a10, ba, op});
    do begin
      apb(1'b0, OFS_STAT, 32'h0000_0000);
      k++;
    end while (q[0] !== 1'b0 && k < 40);
    if (k >= 40) begin
      miscompares++;
      report_and_stop();
    end
    chk("refused", {31'h0, refd}, {31'h0, q[STAT_REF_BIT]});
    chk("pin command", {28'h0, eop}, {28'h0, last_op});
    if (refd) wr(OFS_STAT, 32'h0000_0002);
  endtask : cmd
  task automatic rdat(input logic [15:0] e, input logic [15:0] m);
    apb(1'b0, OFS_RDATA, 32'h0000_0000);
    chk("read data", {16'h0, e & m}, {16'h0, q[15:0] & m});
  endtask : rdat
  // ---------------------------------------------
  // scenarios
  // ---------------------------------------------
  task automatic t_regs();
    apb(1'b0, OFS_CFG, 32'h0000_0000);
    chk("cfg reset", {30'h0, LAT_RST}, q);
    apb(1'b0, OFS_MASK, 32'h0000_0000);
    chk("mask reset", {30'h0, MASK_RST}, q);
    apb(1'b0, 8'h1C, 32'h0000_0000);
    chk("unmapped", 32'h0000_0001, {q[30:0], slv});
    $display("test regs done");
  endtask : t_regs
  task automatic t_init();
    cmd(4'h5, 2'h0, 1'b1, 12'h000, 1'b0, OP_PRE);
    cmd(4'h6, 2'h0, 1'b0, 12'hFFF, 1'b0, OP_REF);
    cmd(4'h8, 2'h0, 1'b0, 12'h020, 1'b0, OP_LMR);
    cmd(4'h8, 2'h2, 1'b0, 12'h000, 1'b0, OP_LMR);
    cmd(4'h8, 2'h1, 1'b0, 12'h000, 1'b1, OP_LMR);
    $display("test init done");
  endtask : t_init
  task automatic t_data();
    cmd(4'h1, 2'h3, 1'b0, 12'h123, 1'b0, OP_ACT);
    stat(4'h8, 1'b0);
    wr(OFS_WDATA, 32'h0000_A5C3);
    cmd(4'h3, 2'h3, 1'b0, 12'h005, 1'b0, OP_WR);
    wr(OFS_WDATA, 32'h0000_1234);
    wr(OFS_MASK, 32'h0000_0001);
    cmd(4'h3, 2'h3, 1'b0, 12'h005, 1'b0, OP_WR);
    wr(OFS_MASK, 32'h0000_0000);
    cmd(4'h2, 2'h3, 1'b0, 12'h005, 1'b0, OP_RD);
    rdat(16'h12C3, 16'hFFFF);
    wr(OFS_MASK, 32'h0000_0002);
    cmd(4'h2, 2'h3, 1'b0, 12'h005, 1'b0, OP_RD);
    rdat(16'h12C3, 16'h00FF);
    $display("test data done");
  endtask : t_data
  task automatic t_refuse();
    cmd(4'h2, 2'h2, 1'b0, 12'h000, 1'b1, OP_RD);
    cmd(4'h1, 2'h3, 1'b0, 12'h000, 1'b1, OP_RD);
    cmd(4'hA, 2'h0, 1'b0, 12'h000, 1'b1, OP_RD);
    cmd(4'h8, 2'h0, 1'b0, 12'h020, 1'b1, OP_RD);
    cmd(4'h6, 2'h0, 1'b0, 12'h000, 1'b1, OP_RD);
    $display("test refuse done");
  endtask : t_refuse
  task automatic t_apre();
    cmd(4'h2, 2'h3, 1'b1, 12'h005, 1'b0, OP_RD);
    stat(4'h0, 1'b0);
    cmd(4'h2, 2'h3, 1'b0, 12'h005, 1'b1, OP_RD);
    cmd(4'h1, 2'h3, 1'b0, 12'h044, 1'b0, OP_ACT);
    cmd(4'h3, 2'h3, 1'b0, 12'h006, 1'b0, OP_WR);
    cmd(4'h4, 2'h3, 1'b0, 12'h000, 1'b0, OP_BST);
    stat(4'h8, 1'b0);
    cmd(4'h5, 2'h3, 1'b0, 12'h000, 1'b0, OP_PRE);
    stat(4'h0, 1'b0);
    $display("test auto precharge done");
  endtask : t_apre
  task automatic t_lat();
    for (int l = 1; l <= 3; l++) begin
      cmd(4'h8, 2'h0, 1'b0, 12'(l << 4), 1'b0, OP_LMR);
      wr(OFS_CFG, 32'(l));
      wr(OFS_MASK, 32'h0000_0000);
      cmd(4'h1, 2'h0, 1'b0, 12'h010, 1'b0, OP_ACT);
      wr(OFS_WDATA, 32'h0000_5A00 + 32'(l));
      cmd(4'h3, 2'h0, 1'b0, 12'(l), 1'b0, OP_WR);
      cmd(4'h2, 2'h0, 1'b1, 12'(l), 1'b0, OP_RD);
      rdat(16'h5A00 + 16'(l), 16'hFFFF);
    end
    $display("test latency done");
  endtask : t_lat
  task automatic t_sref();
    cmd(4'h7, 2'h0, 1'b0, 12'h000, 1'b0, OP_SREF);
    stat(4'h0, 1'b1);
    cmd(4'h1, 2'h2, 1'b0, 12'h000, 1'b1, OP_SREF);
    cmd(4'h9, 2'h0, 1'b0, 12'h000, 1'b0, OP_SRX);
    stat(4'h0, 1'b0);
    cmd(4'h1, 2'h2, 1'b0, 12'h077, 1'b0, OP_ACT);
    wr(OFS_WDATA, 32'h0000_C0DE);
    cmd(4'h3, 2'h2, 1'b0, 12'h009, 1'b0, OP_WR);
    cmd(4'h2, 2'h2, 1'b0, 12'h009, 1'b0, OP_RD);
    rdat(16'hC0DE, 16'hFFFF);
    $display("test self refresh done");
  endtask : t_sref
  initial begin
    repeat (4) @(posedge pclk);
    presetn <= 1;
    @(posedge pclk);
    t_regs();
    t_init();
    t_data();
    t_refuse();
    t_apre();
    t_lat();
    t_sref();
    chk("protocol", 32'h0, 32'(errs));
    report_and_stop();
  end
endmodule : sdc_host_tb_top
`default_nettype wire
